// *** logic/dsd_pkg.sv ***
// Purpose: shared constants and types for the instruction decoder
// Assumes: 16-bit instruction words, one clock domain
// Notes:   opcode patterns are compared against masked first words
package dsd_pkg;

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int PC_W    = 16;
  localparam int CYC_W   = 3;
  localparam int WRD_W   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET     = 16'h0000;
  localparam logic            STATUS_RESET = 1'b0;
  localparam logic [CYC_W-1:0] STALL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // field positions within the first word
  // ----------------------------------------------------------------
  localparam int ADDR_LSB   = 0;   // operand_address_field, 8 bits
  localparam int ADDR_W     = 8;
  localparam int SHIFT4_LSB = 8;   // shift_count_field of the sub form
  localparam int SHIFT4_LONG_LSB = 0; // shift of the long subtract
  localparam int SHIFT3_LSB = 8;   // 3-bit shift of the stores
  localparam int COND_W     = 10;  // 11TP condition field, low 10 bits

  // ----------------------------------------------------------------
  // cycle counts per instruction
  // ----------------------------------------------------------------
  localparam logic [CYC_W-1:0] CYC_ONE       = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO       = 3'h2;
  localparam logic [CYC_W-1:0] CYC_RET_TAKEN = 3'h4;
  localparam logic [CYC_W-1:0] CYC_RET_SKIP  = 3'h2;
  localparam logic [WRD_W-1:0] WORDS_ONE     = 2'h1;
  localparam logic [WRD_W-1:0] WORDS_TWO     = 2'h2;

  // ----------------------------------------------------------------
  // status-set selector nibble
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_BLOCK_PROG = 4'h5;
  localparam logic [3:0] SEL_INT_OFF    = 4'h1;
  localparam logic [3:0] SEL_OVF_MODE   = 4'h3;
  localparam logic [3:0] SEL_TEST_CTRL  = 4'hb;
  localparam logic [3:0] SEL_SIGN_EXT   = 4'h7;
  localparam logic [3:0] SEL_CARRY      = 4'hf;
  localparam logic [3:0] SEL_EXT_FLAG   = 4'hd;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_UNKNOWN            = 5'h00,
    OP_STACK_POP_TO_ACC   = 5'h01,
    OP_STACK_POP_TO_MEM   = 5'h02,
    OP_MEM_PUSH_TO_STACK  = 5'h03,
    OP_ACC_PUSH_TO_STACK  = 5'h04,
    OP_CONDITIONAL_RETURN = 5'h05,
    OP_REPEAT_IMM_COUNT   = 5'h06,
    OP_REPEAT_MEM_COUNT   = 5'h07,
    OP_ACC_HIGH_STORE     = 5'h08,
    OP_ACC_LOW_STORE      = 5'h09,
    OP_AUX_REG_MINUS_IMM  = 5'h0a,
    OP_STATUS_BIT_SET     = 5'h0b,
    OP_PRODUCT_SUBTRACT   = 5'h0c,
    OP_PRODUCT_SHIFT_MODE = 5'h0d,
    OP_SQUARE_THEN_SUB    = 5'h0e,
    OP_LONG_CONST_STORE   = 5'h0f,
    OP_MINUS_LONG_IMM     = 5'h10,
    OP_MINUS_MEM_SHIFT    = 5'h11,
    OP_MINUS_SHORT_IMM    = 5'h12,
    OP_MINUS_WITH_BORROW  = 5'h13,
    OP_MINUS_LOW_UNSIGNED = 5'h14,
    OP_MINUS_VAR_SHIFT    = 5'h15
  } dsd_op_t;

  // decoder sequencing states
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,
    ST_SECOND = 2'b01,
    ST_STALL  = 2'b10
  } dsd_state_t;

endpackage : dsd_pkg

// *** logic/dsd_cls_if.sv ***
// Purpose: carrier between the sequencer and the opcode classifier
// Assumes: purely combinational path
// Notes:   word in, operation and counts out
`timescale 1ns/1ps
interface dsd_cls_if;
  import dsd_pkg::*;
  logic [WORD_W-1:0] word;
  dsd_op_t           op;
  logic [WRD_W-1:0]  words;
  logic              is_return;
  modport seq (output word, input op, words, is_return);
  modport cls (input word, output op, words, is_return);
endinterface : dsd_cls_if

// *** logic/dsd_classify.sv ***
// Purpose: map a first instruction word onto an operation and word count
// Assumes: word is stable for the cycle it is examined
// Notes:   unassigned encodings give the unknown operation
`timescale 1ns/1ps
module dsd_classify (
  // classifier side of the carrier
  dsd_cls_if.cls cls
);
  import dsd_pkg::*;

  // ----------------------------------------------------------------
  // pattern match, most specific first
  // ----------------------------------------------------------------
  always_comb begin
    logic [WORD_W-1:0] w;
    w = cls.word;
    cls.op = OP_UNKNOWN;
    casez (w)
      16'hbe32:          cls.op = OP_STACK_POP_TO_ACC;
      16'hbe3c:          cls.op = OP_ACC_PUSH_TO_STACK;
      16'hbe05:          cls.op = OP_PRODUCT_SUBTRACT;
      16'b1011_1110_0100_????: begin
        if (w[3:0] == SEL_BLOCK_PROG || w[3:0] == SEL_INT_OFF ||
            w[3:0] == SEL_OVF_MODE   || w[3:0] == SEL_TEST_CTRL ||
            w[3:0] == SEL_SIGN_EXT   || w[3:0] == SEL_CARRY ||
            w[3:0] == SEL_EXT_FLAG)
          cls.op = OP_STATUS_BIT_SET;
      end
      16'b1011_1111_1010_????: cls.op = OP_MINUS_LONG_IMM;
      16'b1011_1111_????_????: cls.op = OP_PRODUCT_SHIFT_MODE;
      16'b1000_1010_????_????: cls.op = OP_STACK_POP_TO_MEM;
      16'b0111_0110_????_????: cls.op = OP_MEM_PUSH_TO_STACK;
      16'b1110_11??_????_????: cls.op = OP_CONDITIONAL_RETURN;
      16'b1011_1011_????_????: cls.op = OP_REPEAT_IMM_COUNT;
      16'b0000_1011_????_????: cls.op = OP_REPEAT_MEM_COUNT;
      16'b1001_1???_????_????: cls.op = OP_ACC_HIGH_STORE;
      16'b1001_0???_????_????: cls.op = OP_ACC_LOW_STORE;
      16'b0111_1100_????_????: cls.op = OP_AUX_REG_MINUS_IMM;
      16'b0101_0011_????_????: cls.op = OP_SQUARE_THEN_SUB;
      16'b1010_1110_????_????: cls.op = OP_LONG_CONST_STORE;
      16'b0011_????_????_????: cls.op = OP_MINUS_MEM_SHIFT;
      16'b1011_1010_????_????: cls.op = OP_MINUS_SHORT_IMM;
      16'b0110_0100_????_????: cls.op = OP_MINUS_WITH_BORROW;
      16'b0110_0110_????_????: cls.op = OP_MINUS_LOW_UNSIGNED;
      16'b0110_0111_????_????: cls.op = OP_MINUS_VAR_SHIFT;
      default:           cls.op = OP_UNKNOWN;
    endcase
  end

  // ----------------------------------------------------------------
  // word count and return flag
  // ----------------------------------------------------------------
  // only the two constant-carrying forms occupy a second word
  assign cls.words = (cls.op == OP_LONG_CONST_STORE ||
                      cls.op == OP_MINUS_LONG_IMM) ? WORDS_TWO : WORDS_ONE;
  assign cls.is_return = (cls.op == OP_CONDITIONAL_RETURN);

endmodule : dsd_classify

// *** logic/dsd_decoder.sv ***
// Purpose: instruction decoder for stack, repeat, store, status-set
//          and subtract operations of a 16-bit fixed-point processor
// Assumes: program memory and datapath share sys_clk
// Notes:   one decoded operation is issued per instruction, then the
//          word port is held off for the rest of its cycle count
//
// Functional notes
// - pattern be32 moves top of stack into low accumulator half.
// - upper byte 8a plus address pops stack into data memory.
// - upper byte 76 plus address pushes data-memory word onto stack.
// - pattern be3c pushes low accumulator half onto the stack.
// - upper bits 111011 conditional return; four cycles taken, two not.
// - upper byte bb repeats next instruction by immediate 8-bit count.
// - upper byte 0b repeats next instruction, count from data memory.
// - nibble 1001 then 1 and shift stores shifted high accumulator.
// - nibble 1001 then 0 and shift stores shifted low accumulator.
// - upper byte 7c subtracts immediate from current auxiliary register.
// - be4x with one of seven selector nibbles sets the status bit it chooses.
// - pattern be4d drives the external flag output high.
// - pattern be05 subtracts product register from accumulator.
// - upper byte bf single-word form selects product shift mode.
// - upper byte 53 squares operand, subtracts previous product.
// - upper byte ae plus constant word stores constant; two words, cycles.
// - bfa plus shift and constant word subtracts shifted constant.
// - nibble 0011 with shift and address subtracts shifted operand.
// - upper byte ba subtracts short immediate from accumulator.
// - upper byte 64 subtracts operand and inverted carry as borrow.
// - upper byte 66 subtracts from low half, sign extension off.
// - upper byte 67 subtracts operand shifted by multiplicand register.
`timescale 1ns/1ps
module dsd_decoder (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  // program memory word stream
  input  wire logic [dsd_pkg::WORD_W-1:0] pm_word,
  input  wire logic                    pm_valid,
  output logic                         pm_ready,
  output logic [dsd_pkg::PC_W-1:0]     pc_out,
  // condition result from the datapath
  input  wire logic                    cond_met,
  // decoded operation to the datapath
  output logic                         dec_valid,
  output dsd_pkg::dsd_op_t             dec_op,
  output logic [dsd_pkg::WORD_W-1:0]   dec_word,
  output logic [dsd_pkg::ADDR_W-1:0]   dec_addr,
  output logic [3:0]                   dec_shift,
  output logic [dsd_pkg::COND_W-1:0]   dec_cond,
  output logic [dsd_pkg::WORD_W-1:0]   dec_const,
  output logic [dsd_pkg::WRD_W-1:0]    dec_words,
  output logic [dsd_pkg::CYC_W-1:0]    dec_cycles,
  output logic                         dec_ret_taken,
  output logic                         dec_unknown,
  // status bits and pin
  output logic                         st_block_prog,
  output logic                         st_int_off,
  output logic                         st_ovf_mode,
  output logic                         st_test_ctrl,
  output logic                         st_sign_ext,
  output logic                         st_carry,
  output logic                         external_flag_pin
);
  import dsd_pkg::*;

  // --------
  // state and registers
  // --------
  dsd_state_t          state_r;
  logic [WORD_W-1:0]   first_r;      // first word held across fetches
  logic [CYC_W-1:0]    stall_r;      // cycles left of the current op
  logic [PC_W-1:0]     pc_r;
  logic                dec_valid_r;
  dsd_op_t             dec_op_r;
  logic [WORD_W-1:0]   dec_word_r;
  logic [ADDR_W-1:0]   dec_addr_r;
  logic [3:0]          dec_shift_r;
  logic [COND_W-1:0]   dec_cond_r;
  logic [WORD_W-1:0]   dec_const_r;
  logic [WRD_W-1:0]    dec_words_r;
  logic [CYC_W-1:0]    dec_cycles_r;
  logic                dec_ret_r;
  logic [6:0]          status_r;     // six status bits plus flag pin

  // --------
  // classifier
  // --------
  dsd_cls_if cls_bus ();

  // second fetch re-examines the held first word, not the constant
  assign cls_bus.word = (state_r == ST_SECOND) ? first_r : pm_word;

  dsd_classify u_classify (
    .cls (cls_bus.cls)
  );

  // --------
  // handshake and issue conditions
  // --------
  logic take;
  logic issue;
  logic [WORD_W-1:0] iss_word;
  logic [CYC_W-1:0]  iss_cycles;
  logic [CYC_W-1:0]  iss_stall;

  assign pm_ready = (state_r == ST_FIRST) || (state_r == ST_SECOND);
  assign take     = pm_valid && pm_ready;
  // one-word ops issue on the first fetch, two-word ops on the second
  assign issue    = take && ((state_r == ST_SECOND) ||
                             (cls_bus.words == WORDS_ONE));
  assign iss_word = (state_r == ST_SECOND) ? first_r : pm_word;

  // cycle count: return depends on the condition sampled at issue
  always_comb begin
    iss_cycles = CYC_ONE;
    if (cls_bus.is_return) begin
      iss_cycles = cond_met ? CYC_RET_TAKEN : CYC_RET_SKIP;
    end else if (cls_bus.words == WORDS_TWO) begin
      iss_cycles = CYC_TWO;
    end
  end

  // fetch cycles already spent count toward the instruction's cycles
  assign iss_stall = iss_cycles - {1'b0, cls_bus.words};

  // --------
  // sequencer
  // --------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_FIRST;
      stall_r <= STALL_RESET;
      first_r <= '0;
    end else begin
      case (state_r)
        ST_FIRST: begin
          if (take) begin
            first_r <= pm_word;
            if (cls_bus.words == WORDS_TWO) begin
              state_r <= ST_SECOND;
            end else if (iss_stall != STALL_RESET) begin
              state_r <= ST_STALL;
              stall_r <= iss_stall;
            end
          end
        end
        ST_SECOND: begin
          if (take) begin
            if (iss_stall != STALL_RESET) begin
              state_r <= ST_STALL;
              stall_r <= iss_stall;
            end else begin
              state_r <= ST_FIRST;
            end
          end
        end
        ST_STALL: begin
          // hold the word port off until the op's cycles are used up
          stall_r <= stall_r - CYC_ONE;
          if (stall_r == CYC_ONE) begin
            state_r <= ST_FIRST;
          end
        end
        default: begin
          state_r <= ST_FIRST;
        end
      endcase
    end
  end

  // --------
  // program counter
  // --------
  // every accepted word advances it, so two-word ops skip the constant
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= PC_RESET;
    end else if (take) begin
      pc_r <= pc_r + 16'h0001;
    end
  end

  // --------
  // decoded operation outputs
  // --------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid_r  <= 1'b0;
      dec_op_r     <= OP_UNKNOWN;
      dec_word_r   <= '0;
      dec_addr_r   <= '0;
      dec_shift_r  <= 4'h0;
      dec_cond_r   <= '0;
      dec_const_r  <= '0;
      dec_words_r  <= '0;
      dec_cycles_r <= '0;
      dec_ret_r    <= 1'b0;
    end else begin
      dec_valid_r <= issue;
      if (issue) begin
        dec_op_r     <= cls_bus.op;
        dec_word_r   <= iss_word;
        dec_addr_r   <= iss_word[ADDR_LSB +: ADDR_W];
        dec_cond_r   <= iss_word[COND_W-1:0];
        dec_words_r  <= cls_bus.words;
        dec_cycles_r <= iss_cycles;
        dec_ret_r    <= cls_bus.is_return && cond_met;
        // constant word only for the two-word forms
        dec_const_r  <= (state_r == ST_SECOND) ? pm_word : '0;
        case (cls_bus.op)
          OP_ACC_HIGH_STORE,
          OP_ACC_LOW_STORE:
            dec_shift_r <= {1'b0, iss_word[SHIFT3_LSB +: 3]};
          OP_MINUS_MEM_SHIFT:
            dec_shift_r <= iss_word[SHIFT4_LSB +: 4];
          OP_MINUS_LONG_IMM:
            dec_shift_r <= iss_word[SHIFT4_LONG_LSB +: 4];
          default:
            dec_shift_r <= 4'h0;
        endcase
      end
    end
  end

  // --------
  // status bits and external flag
  // --------
  // set-only here; clearing forms belong to other decoder slices
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= {7{STATUS_RESET}};
    end else if (issue && cls_bus.op == OP_STATUS_BIT_SET) begin
      case (iss_word[3:0])
        SEL_BLOCK_PROG: status_r[0] <= 1'b1;
        SEL_INT_OFF:    status_r[1] <= 1'b1;
        SEL_OVF_MODE:   status_r[2] <= 1'b1;
        SEL_TEST_CTRL:  status_r[3] <= 1'b1;
        SEL_SIGN_EXT:   status_r[4] <= 1'b1;
        SEL_CARRY:      status_r[5] <= 1'b1;
        SEL_EXT_FLAG:   status_r[6] <= 1'b1;
        default:        status_r    <= status_r;
      endcase
    end
  end

  // --------
  // output drive
  // --------
  assign pc_out            = pc_r;
  assign dec_valid         = dec_valid_r;
  assign dec_op            = dec_op_r;
  assign dec_word          = dec_word_r;
  assign dec_addr          = dec_addr_r;
  assign dec_shift         = dec_shift_r;
  assign dec_cond          = dec_cond_r;
  assign dec_const         = dec_const_r;
  assign dec_words         = dec_words_r;
  assign dec_cycles        = dec_cycles_r;
  assign dec_ret_taken     = dec_ret_r;
  assign dec_unknown       = dec_valid_r && (dec_op_r == OP_UNKNOWN);
  assign st_block_prog     = status_r[0];
  assign st_int_off        = status_r[1];
  assign st_ovf_mode       = status_r[2];
  assign st_test_ctrl      = status_r[3];
  assign st_sign_ext       = status_r[4];
  assign st_carry          = status_r[5];
  assign external_flag_pin = status_r[6];

endmodule : dsd_decoder

// *** test/dsd_monitor.sv ***
// Purpose: port-level checks of the instruction decoder
// Assumes: single clock, asynchronous active-low reset
// Notes:   bound into dsd_decoder below the module
`timescale 1ns/1ps
module dsd_monitor (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  // word port
  input wire logic [dsd_pkg::WORD_W-1:0] pm_word,
  input wire logic                       pm_valid,
  input wire logic                       pm_ready,
  input wire logic [dsd_pkg::PC_W-1:0]   pc_out,
  // decoded operation
  input wire logic                       dec_valid,
  input wire dsd_pkg::dsd_op_t           dec_op,
  input wire logic [dsd_pkg::WORD_W-1:0] dec_word,
  input wire logic [3:0]                 dec_shift,
  input wire logic [dsd_pkg::WORD_W-1:0] dec_const,
  input wire logic [dsd_pkg::WRD_W-1:0]  dec_words,
  input wire logic [dsd_pkg::CYC_W-1:0]  dec_cycles,
  input wire logic                       dec_ret_taken,
  input wire logic                       dec_unknown,
  // status
  input wire logic                       st_int_off,
  input wire logic                       st_carry,
  input wire logic                       external_flag_pin
);
  import dsd_pkg::*;
  // --------
  // checks
  // --------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  issue_cause_a: assert property (
    dec_valid |-> $past(pm_valid && pm_ready))
    else $error("issue without an accepted word");
  pc_step_a: assert property (
    pm_valid && pm_ready |=> pc_out == $past(pc_out) + 16'h1)
    else $error("word count did not step by one");
  ret_hold_a: assert property (
    dec_valid && dec_ret_taken |-> !pm_ready [*3] ##1 pm_ready)
    else $error("taken return hold-off wrong");
  ret_skip_a: assert property (
    dec_valid && dec_op == OP_CONDITIONAL_RETURN && !dec_ret_taken
      |-> !pm_ready ##1 pm_ready)
    else $error("skipped return hold-off wrong");
  ret_cycles_a: assert property (
    dec_valid && dec_op == OP_CONDITIONAL_RETURN
      |-> dec_cycles == (dec_ret_taken ? CYC_RET_TAKEN : CYC_RET_SKIP))
    else $error("return cycle count wrong");
  long_pair_a: assert property (
    dec_valid && dec_op inside {OP_LONG_CONST_STORE, OP_MINUS_LONG_IMM}
      |-> dec_words == WORDS_TWO && dec_cycles == CYC_TWO
      && dec_const == $past(pm_word))
    else $error("two-word issue wrong");
  single_word_a: assert property (
    dec_valid && !(dec_op inside {OP_LONG_CONST_STORE, OP_MINUS_LONG_IMM,
      OP_CONDITIONAL_RETURN}) |-> dec_words == WORDS_ONE
      && dec_cycles == CYC_ONE && pm_ready)
    else $error("one-word issue counts wrong");
  store_shift_a: assert property (
    dec_valid && dec_op inside {OP_ACC_HIGH_STORE, OP_ACC_LOW_STORE}
      |-> dec_shift == {1'b0, dec_word[10:8]} && dec_word[15:12] == 4'h9
      && dec_word[11] == (dec_op == OP_ACC_HIGH_STORE))
    else $error("store decode wrong");
  flag_cause_a: assert property (
    $rose(external_flag_pin) |-> dec_valid && dec_word == 16'hbe4d)
    else $error("flag rose without its word");
  int_off_a: assert property (
    $rose(st_int_off) |-> dec_valid && dec_word == 16'hbe41)
    else $error("interrupt-off bit rose without its word");
  carry_set_a: assert property (
    dec_valid && dec_word == 16'hbe4f |-> st_carry)
    else $error("carry bit not set");
  unknown_a: assert property (
    dec_unknown |-> dec_valid && dec_op == OP_UNKNOWN)
    else $error("unknown flag without unknown issue");
endmodule : dsd_monitor

bind dsd_decoder dsd_monitor dsd_monitor_inst (.*);

// *** test/dsd_pm_model.sv ***
// Purpose: program memory model feeding the decoder word port
// Assumes: the bench queues words away from the rising edge
// Notes:   idle word lines toggle so stale data is never mistaken
`timescale 1ns/1ps
module dsd_pm_model (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  // pacing
  input  wire logic                       slow,
  // word stream
  input  wire logic                       pm_ready,
  output logic [dsd_pkg::WORD_W-1:0]      pm_word,
  output logic                            pm_valid
);
  import dsd_pkg::*;
  logic [WORD_W-1:0] q [$];
  logic              gap_r;
  initial pm_word = 16'h5a5a;
  initial pm_valid = 1'b0;
  // bench side: queue one word
  task automatic push(input logic [WORD_W-1:0] w);
    q.push_back(w);
  endtask : push
  // --------
  // word presentation
  // --------
  // an offered word is held until taken; slow idles every other cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.delete();
      gap_r    <= 1'b0;
      pm_valid <= 1'b0;
      pm_word  <= ~pm_word;
    end else if (!(pm_valid && !pm_ready)) begin
      if (pm_valid) void'(q.pop_front());
      gap_r <= slow && !gap_r;
      if (q.size() > 0 && !(slow && !gap_r)) begin
        pm_valid <= 1'b1;
        pm_word  <= q[0];
      end else begin
        pm_valid <= 1'b0;
        pm_word  <= ~pm_word; // no stale word while idle
      end
    end
  end
endmodule : dsd_pm_model

// *** test/dsd_decoder_test.sv ***
// Purpose: self-checking bench for the instruction decoder
// Assumes: memory model feeds words; condition input driven here
// Notes:   each scenario is a task that judges its own results
`timescale 1ns/1ps
module dsd_decoder_test;
  import dsd_pkg::*;
  typedef struct { logic [15:0] w; dsd_op_t op; logic [3:0] sh; } dsd_case_t;
  // --------
  // signals
  // --------
  logic sys_clk = 1'b0;
  logic reset_n, cond_met, slow, pm_valid, pm_ready, dec_valid;
  logic dec_ret_taken, dec_unknown, external_flag_pin;
  logic st_block_prog, st_int_off, st_ovf_mode, st_test_ctrl;
  logic st_sign_ext, st_carry;
  logic [15:0] pm_word, pc_out, dec_word, dec_const;
  logic [7:0]  dec_addr;
  logic [3:0]  dec_shift;
  logic [9:0]  dec_cond;
  logic [1:0]  dec_words;
  logic [2:0]  dec_cycles;
  dsd_op_t     dec_op;
  int          n_errors = 0;
  int          checked  = 0;
  wire  [6:0]  st_all = {st_block_prog, st_int_off, st_ovf_mode,
                         st_test_ctrl, st_sign_ext, st_carry,
                         external_flag_pin};
  dsd_case_t tbl [25] = '{
    '{16'hbe32, OP_STACK_POP_TO_ACC, 4'h0},
    '{16'h8a12, OP_STACK_POP_TO_MEM, 4'h0},
    '{16'h7634, OP_MEM_PUSH_TO_STACK, 4'h0},
    '{16'hbe3c, OP_ACC_PUSH_TO_STACK, 4'h0},
    '{16'hbb05, OP_REPEAT_IMM_COUNT, 4'h0},
    '{16'h0b44, OP_REPEAT_MEM_COUNT, 4'h0},
    '{16'h9d55, OP_ACC_HIGH_STORE, 4'h5}, '{16'h9366, OP_ACC_LOW_STORE, 4'h3},
    '{16'h7c07, OP_AUX_REG_MINUS_IMM, 4'h0},
    '{16'hbe05, OP_PRODUCT_SUBTRACT, 4'h0},
    '{16'hbf02, OP_PRODUCT_SHIFT_MODE, 4'h0},
    '{16'h5377, OP_SQUARE_THEN_SUB, 4'h0},
    '{16'h3a88, OP_MINUS_MEM_SHIFT, 4'ha}, '{16'hba09, OP_MINUS_SHORT_IMM, 4'h0},
    '{16'h6499, OP_MINUS_WITH_BORROW, 4'h0},
    '{16'h66aa, OP_MINUS_LOW_UNSIGNED, 4'h0},
    '{16'h67bb, OP_MINUS_VAR_SHIFT, 4'h0}, '{16'hbe45, OP_STATUS_BIT_SET, 4'h0},
    '{16'hbe41, OP_STATUS_BIT_SET, 4'h0}, '{16'hbe43, OP_STATUS_BIT_SET, 4'h0},
    '{16'hbe4b, OP_STATUS_BIT_SET, 4'h0}, '{16'hbe47, OP_STATUS_BIT_SET, 4'h0},
    '{16'hbe4f, OP_STATUS_BIT_SET, 4'h0}, '{16'hbe4d, OP_STATUS_BIT_SET, 4'h0},
    '{16'hbe4e, OP_UNKNOWN, 4'h0}};
  dsd_decoder dsd_decoder_inst (
    .sys_clk, .reset_n, .pm_word, .pm_valid, .pm_ready, .pc_out, .cond_met,
    .dec_valid, .dec_op, .dec_word, .dec_addr, .dec_shift, .dec_cond,
    .dec_const, .dec_words, .dec_cycles, .dec_ret_taken, .dec_unknown,
    .st_block_prog, .st_int_off, .st_ovf_mode, .st_test_ctrl, .st_sign_ext,
    .st_carry, .external_flag_pin);
  dsd_pm_model dsd_pm_model_inst (
    .sys_clk, .reset_n, .slow, .pm_ready, .pm_word, .pm_valid);
  // --------
  // helpers
  // --------
  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_len(input logic [1:0] w, input logic [2:0] c);
    chk("words", w, dec_words);
    chk("cycles", c, dec_cycles);
  endtask : chk_len
  // words are queued at the falling edge, clear of the sampling edge
  task automatic put(input logic [15:0] w);
    dsd_pm_model_inst.push(w);
  endtask : put
  // bounded wait for the next issue pulse
  task automatic wait_issue(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (dec_valid !== 1'b1 && n < 20);
    chk("issue", 1, dec_valid);
  endtask : wait_issue
  task automatic chk_idle;
    chk("ready", 1, pm_ready);
    chk("count", 0, pc_out);
    chk("status", 0, st_all);
    chk("valid", 0, dec_valid);
  endtask : chk_idle
  // --------
  // scenarios
  // --------
  // every one-word form except the return, back to back, then all status bits stand
  task automatic one_word_table;
    int n;
    @(negedge sys_clk);
    foreach (tbl[i]) put(tbl[i].w);
    foreach (tbl[i]) begin
      wait_issue(n);
      if (i > 0) chk("gap", 1, n);
      chk("op", tbl[i].op, dec_op);
      chk("shift", tbl[i].sh, dec_shift);
      chk("addr", tbl[i].w[7:0], dec_addr);
      chk("unknown", tbl[i].op == OP_UNKNOWN, dec_unknown);
      chk_len(WORDS_ONE, CYC_ONE);
    end
    chk("count", 25, pc_out);
    chk("status", 7'h7f, st_all);
  endtask : one_word_table
  // two-word forms from a memory that idles between words
  task automatic two_word_slow;
    int n;
    logic [15:0] pc0;
    @(posedge sys_clk);
    slow <= 1'b1;
    @(negedge sys_clk);
    pc0 = pc_out;
    put(16'hae10);
    put(16'h1234);
    put(16'hbfa3);
    put(16'h5678);
    wait_issue(n);
    chk("op", OP_LONG_CONST_STORE, dec_op);
    chk("const", 16'h1234, dec_const);
    chk("addr", 8'h10, dec_addr);
    chk_len(WORDS_TWO, CYC_TWO);
    wait_issue(n);
    chk("op", OP_MINUS_LONG_IMM, dec_op);
    chk("const", 16'h5678, dec_const);
    chk("shift", 4'h3, dec_shift);
    chk_len(WORDS_TWO, CYC_TWO);
    chk("count", pc0 + 4, pc_out);
    @(posedge sys_clk);
    slow <= 1'b0;
  endtask : two_word_slow
  // taken and skipped return, each followed at once by another word
  task automatic returns;
    int n;
    logic [15:0] rw;
    for (int k = 1; k >= 0; k--) begin
      rw = k ? 16'hef00 : 16'hec3f;
      @(posedge sys_clk);
      cond_met <= k[0];
      @(negedge sys_clk);
      put(rw);
      put(16'hbe32);
      wait_issue(n);
      chk("op", OP_CONDITIONAL_RETURN, dec_op);
      chk("taken", k, dec_ret_taken);
      chk("cond", rw[9:0], dec_cond);
      chk_len(WORDS_ONE, k ? CYC_RET_TAKEN : CYC_RET_SKIP);
      n = 0;
      while (pm_ready === 1'b0 && n < 10) begin
        n++;
        @(posedge sys_clk);
        #1;
      end
      chk("hold off", k ? 3 : 1, n);
      wait_issue(n);
      chk("op", OP_STACK_POP_TO_ACC, dec_op);
    end
  endtask : returns
  // reset in mid-run clears all status, then the flag alone comes back
  task automatic mid_reset;
    int n;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(negedge sys_clk);
    chk_idle();
    @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    put(16'hbe4d);
    wait_issue(n);
    chk("flag only", 7'h01, st_all);
  endtask : mid_reset
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // --------
  // run
  // --------
  always #25 sys_clk = ~sys_clk;
  initial begin
    reset_n = 1'b0;
    cond_met = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_idle();
    reset_n <= 1'b1;
    one_word_table();
    $display("test one_word_table done");
    two_word_slow();
    $display("test two_word_slow done");
    returns();
    $display("test returns done");
    mid_reset();
    $display("test mid_reset done");
    close_out();
  end
  // about 60 cycles of work; a hang is cut well past that
  initial begin
    #(2000 * 50);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end
endmodule : dsd_decoder_test
